// >>> include/halt_ctrl_pkg.sv
// Constants for the processor halt-request and throttle controller.
// Assumes a 25 MHz reference clock and an APB register bus.
package halt_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [9:0] BURST_IDX = 10'h0D3;
  localparam logic [9:0] CLKCTL_IDX = 10'h0D4;
  localparam logic [9:0] ASSERT_IDX = 10'h0D6;
  localparam logic [9:0] NEGATE_IDX = 10'h0D7;
  localparam logic [9:0] BRK_LO_IDX = 10'h0D8;
  localparam logic [9:0] BRK_HI_IDX = 10'h0D9;
  localparam logic [9:0] STATUS_IDX = 10'h0DB;
  // Reset values
  localparam logic [7:0] BURST_RST = 8'h00;
  localparam logic [7:0] CLKCTL_RST = 8'h00;
  localparam logic [7:0] ASSERT_RST = 8'h00;
  localparam logic [7:0] NEGATE_RST = 8'h00;
  localparam logic [7:0] BRK_LO_RST = 8'h00;
  localparam logic [7:0] BRK_HI_RST = 8'h00;
  // Clock control fields
  localparam int CC_BUSCLK_BIT = 0;
  localparam int CC_THROTTLE_BIT = 1;
  localparam int CC_MODE_LSB = 2;
  localparam int CC_AUTO_BIT = 4;
  localparam int CC_STBY_BIT = 7;
  localparam logic [7:0] CLKCTL_MASK = 8'h9F;
  // Writable break enables; reserved lines read zero
  localparam logic [7:0] BRK_LO_MASK = 8'hFB;
  localparam logic [7:0] BRK_HI_MASK = 8'hDF;
  // Halt request modes
  localparam logic [1:0] MODE_OFF = 2'b00;
  localparam logic [1:0] MODE_GRANT = 2'b01;
  localparam logic [1:0] MODE_STOP = 2'b10;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_US = 32;
  localparam int TICK_CYC = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int STBY_FINE_MS = 4;
  localparam int STBY_COARSE_MS = 32;
  localparam int STBY_FINE_TICKS = (STBY_FINE_MS * 1000) / TICK_US;
  localparam int STBY_COARSE_TICKS = (STBY_COARSE_MS * 1000) / TICK_US;
  typedef enum logic [1:0] {ST_IDLE, ST_ASSERT, ST_NEGATE, ST_BURST} halt_state_t;
endpackage : halt_ctrl_pkg

// >>> rtl/halt_throttle_ctrl.sv
// Processor halt-request controller with throttling, burst timer and break events.
// Assumes an APB master on ref_clk_i; IRQ and burst pins are asynchronous.
// Functional notes
// (RL1) Auto throttle: 8-bit burst count sets negated time after a burst event.
// (RL2) Burst timer decrements once per 32 us tick, span one tick to 8 ms.
// (RL3) Every enabled burst event reloads the burst timer from its count; one in the same cycle as sw_req or brk_evt does not reload.
// (RL4) Burst timer expiry asserts the halt request again.
// (RL5) Clock control bit 7 picks standby tick: 0 is 4 ms, 1 is 32 ms.
// (RL6) Clock control bit 4 enables automatic throttle mode.
// (RL7) Nonzero mode field makes a control port read assert the halt request.
// (RL8) Mode 00 off, 01 stop-grant, 10 stop-clock, 11 reserved.
// (RL9) Clock control bit 1 enables periodic throttling.
// (RL10) Clock control bit 0 permits the bus clock to be stopped.
// (RL11) Each assertion while throttling loads the assert-period count.
// (RL12) Each negation while throttling loads the negate-period count.
// (RL13) Software never programs either throttle count as zero.
// (RL14) Throttle timer counts 32 us ticks, one tick up to 8 ms.
// (RL15) Enabled break event negates the request and reloads the negate count; one in the same cycle as sw_req does not, the request asserts.
// (RL16) Low break byte enables lines 0,1,3-7; bit 2 reserved.
// (RL17) High break byte enables lines 8-12,14,15; bit 5 reserved.
// (RL18) Throttling alternates asserted and negated periods, reloading each time.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module halt_throttle_ctrl (
  input wire logic ref_clk_i, // 25 MHz clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [halt_ctrl_pkg::ADDR_W-1:0] paddr_i, // APB byte address
  input wire logic [halt_ctrl_pkg::DATA_W-1:0] pwdata_i, // APB write data
  output logic [halt_ctrl_pkg::DATA_W-1:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped
  input wire logic pm_port_read_i, // Control port read pulse
  input wire logic [halt_ctrl_pkg::IRQ_W-1:0] irq_i, // Interrupt pins
  input wire logic burst_event_i, // Burst clock event pin
  output logic cpu_halt_request_n_o, // Halt request, active low
  output logic [1:0] halt_request_mode_o, // Halt request mode
  output logic bus_clock_stop_en_o, // Bus clock may stop
  output logic standby_tick_o // Standby timer tick
);
  import halt_ctrl_pkg::*;

  logic [7:0] burst_cnt_r;
  logic [7:0] clk_ctl_r;
  logic [7:0] assert_cnt_r;
  logic [7:0] negate_cnt_r;
  logic [7:0] brk_lo_r;
  logic [7:0] brk_hi_r;
  logic [DATA_W-1:0] prdata_r;
  logic [9:0] idx;
  logic mapped;
  logic wr_en;
  logic rd_setup;
  logic [DATA_W-1:0] rd_val;
  halt_state_t state_r;
  halt_state_t state_nxt;
  logic [7:0] tmr_r;
  logic [7:0] tmr_nxt;
  logic halt_n_r;
  logic sw_hold_r;
  logic [IRQ_W-1:0] irq_s;
  logic [IRQ_W-1:0] irq_d_r;
  logic burst_s;
  logic burst_d_r;
  logic tick;
  logic expire;
  logic thr_en;
  logic auto_en;
  logic sw_req;
  logic brk_evt;
  logic burst_evt;
  logic [9:0] stby_cnt_r;
  logic [9:0] stby_last;
  logic stby_tick_r;

  assign idx = paddr_i[11:2];
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign thr_en = clk_ctl_r[CC_THROTTLE_BIT]; // RL9
  assign auto_en = clk_ctl_r[CC_AUTO_BIT];

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_val = '0;
    if (idx == BURST_IDX) begin
      rd_val[7:0] = burst_cnt_r;
    end else if (idx == CLKCTL_IDX) begin
      rd_val[7:0] = clk_ctl_r;
    end else if (idx == ASSERT_IDX) begin
      rd_val[7:0] = assert_cnt_r;
    end else if (idx == NEGATE_IDX) begin
      rd_val[7:0] = negate_cnt_r;
    end else if (idx == BRK_LO_IDX) begin
      rd_val[7:0] = brk_lo_r;
    end else if (idx == BRK_HI_IDX) begin
      rd_val[7:0] = brk_hi_r;
    end else if (idx == STATUS_IDX) begin
      rd_val = {16'h0000, tmr_r, 5'h00, sw_hold_r, (state_r == ST_BURST), !halt_n_r};
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o = prdata_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prdata_r <= '0;
    end else if (rd_setup) begin
      prdata_r <= rd_val;
    end
  end

  // Register writes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      burst_cnt_r <= BURST_RST;
      clk_ctl_r <= CLKCTL_RST;
      assert_cnt_r <= ASSERT_RST;
      negate_cnt_r <= NEGATE_RST;
      brk_lo_r <= BRK_LO_RST;
      brk_hi_r <= BRK_HI_RST;
    end else if (wr_en) begin
      if (idx == BURST_IDX) begin
        burst_cnt_r <= pwdata_i[7:0]; // RL1
      end else if (idx == CLKCTL_IDX) begin
        clk_ctl_r <= pwdata_i[7:0] & CLKCTL_MASK; // RL6
      end else if (idx == ASSERT_IDX) begin
        assert_cnt_r <= pwdata_i[7:0];
      end else if (idx == NEGATE_IDX) begin
        negate_cnt_r <= pwdata_i[7:0];
      end else if (idx == BRK_LO_IDX) begin
        brk_lo_r <= pwdata_i[7:0] & BRK_LO_MASK; // RL16
      end else if (idx == BRK_HI_IDX) begin
        brk_hi_r <= pwdata_i[7:0] & BRK_HI_MASK; // RL17
      end
    end
  end

  assign halt_request_mode_o = clk_ctl_r[CC_MODE_LSB +: 2]; // RL8
  assign bus_clock_stop_en_o = clk_ctl_r[CC_BUSCLK_BIT]; // RL10

  // Pin synchronisers and edge detection
  sync_bank #(.WIDTH(IRQ_W + 1)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({burst_event_i, irq_i}),
    .sync_o({burst_s, irq_s})
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_d_r <= '0;
      burst_d_r <= 1'b0;
    end else begin
      irq_d_r <= irq_s;
      burst_d_r <= burst_s;
    end
  end

  assign brk_evt = |(irq_s & ~irq_d_r & {brk_hi_r, brk_lo_r}); // RL16 RL17
  assign burst_evt = auto_en && burst_s && !burst_d_r; // RL6
  assign sw_req = pm_port_read_i && (halt_request_mode_o != MODE_OFF); // RL7

  // 32 us time base
  tick_pulse #(.PERIOD(TICK_CYC)) u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );

  assign expire = tick && (tmr_r == 8'h01); // RL2 RL14

  // Software hold: the port read sets it, a break clears it, set wins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sw_hold_r <= 1'b0;
    end else if (sw_req) begin
      sw_hold_r <= 1'b1; // RL7
    end else if (brk_evt) begin
      sw_hold_r <= 1'b0;
    end
  end

  // Halt request sequencer
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tick ? tmr_r - 8'h01 : tmr_r; // RL2 RL14
    if (sw_req) begin
      state_nxt = ST_ASSERT; // RL7
      tmr_nxt = assert_cnt_r; // RL11
    end else if (brk_evt) begin
      state_nxt = thr_en ? ST_NEGATE : ST_IDLE; // RL15
      tmr_nxt = negate_cnt_r; // RL15
    end else if (burst_evt) begin
      state_nxt = ST_BURST; // RL1
      tmr_nxt = burst_cnt_r; // RL3
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (thr_en) begin
            state_nxt = ST_ASSERT;
            tmr_nxt = assert_cnt_r; // RL11
          end
        end
        ST_ASSERT: begin
          if (thr_en && expire) begin
            state_nxt = ST_NEGATE; // RL18
            tmr_nxt = negate_cnt_r; // RL12
          end else if (!thr_en && !sw_hold_r && !auto_en) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_NEGATE: begin
          if (!thr_en) begin
            state_nxt = ST_IDLE;
          end else if (expire) begin
            state_nxt = ST_ASSERT; // RL18
            tmr_nxt = assert_cnt_r; // RL11
          end
        end
        ST_BURST: begin
          if (expire) begin
            state_nxt = ST_ASSERT; // RL4
            tmr_nxt = assert_cnt_r; // RL11
          end else if (!auto_en) begin
            state_nxt = thr_en ? ST_NEGATE : ST_IDLE;
            tmr_nxt = negate_cnt_r; // RL12
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      tmr_r <= 8'h00;
      halt_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      halt_n_r <= (state_nxt != ST_ASSERT);
    end
  end

  assign cpu_halt_request_n_o = halt_n_r;

  // Standby timer granularity
  assign stby_last = clk_ctl_r[CC_STBY_BIT] ? 10'(STBY_COARSE_TICKS - 1)
                                            : 10'(STBY_FINE_TICKS - 1); // RL5
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      stby_cnt_r <= 10'h000;
      stby_tick_r <= 1'b0;
    end else begin
      stby_tick_r <= tick && (stby_cnt_r >= stby_last); // RL5
      if (tick) begin
        stby_cnt_r <= (stby_cnt_r >= stby_last) ? 10'h000 : stby_cnt_r + 10'h001;
      end
    end
  end

  assign standby_tick_o = stby_tick_r;

  // Checks
  logic quiet;
  logic [11:0] gap_r;
  assign quiet = !sw_req && !brk_evt && !burst_evt;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      // Aligned with the divider so the first tick is checked too
      gap_r <= 12'hFFF;
    end else begin
      gap_r <= tick ? 12'h000 : gap_r + 12'h001;
    end
  end

  property p_port_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      pm_port_read_i && (clk_ctl_r[3:2] != 2'b00) |=> !cpu_halt_request_n_o && tmr_r == $past(assert_cnt_r);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read did not assert request"); // RL7

  property p_mode_off;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      pm_port_read_i && clk_ctl_r[3:2] == 2'b00 && state_r == ST_IDLE && !thr_en && !auto_en && !brk_evt
      |=> cpu_halt_request_n_o;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("port read acted in mode off"); // RL8

  property p_break;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      brk_evt && !sw_req |=> cpu_halt_request_n_o && tmr_r == $past(negate_cnt_r);
  endproperty
  a_break: assert property (p_break) else $error("break did not release request"); // RL15

  property p_thr_assert;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      state_r == ST_NEGATE && thr_en && expire && quiet
      |=> !cpu_halt_request_n_o && tmr_r == $past(assert_cnt_r);
  endproperty
  a_thr_assert: assert property (p_thr_assert) else $error("assert count not loaded"); // RL11

  property p_thr_negate;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      state_r == ST_ASSERT && thr_en && expire && quiet
      |=> cpu_halt_request_n_o && tmr_r == $past(negate_cnt_r);
  endproperty
  a_thr_negate: assert property (p_thr_negate) else $error("negate count not loaded"); // RL12

  property p_burst_load;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      burst_evt && !sw_req && !brk_evt |=> state_r == ST_BURST && tmr_r == $past(burst_cnt_r);
  endproperty
  a_burst_load: assert property (p_burst_load) else $error("burst timer not reloaded"); // RL3

  property p_burst_exp;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      state_r == ST_BURST && expire && quiet |=> !cpu_halt_request_n_o;
  endproperty
  a_burst_exp: assert property (p_burst_exp) else $error("burst expiry did not assert"); // RL4

  property p_tick_gap;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      tick |-> gap_r == 12'(TICK_CYC - 1);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong"); // RL14

  property p_hold;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      state_r == ST_NEGATE && thr_en && !tick && quiet |=> $stable(tmr_r) && cpu_halt_request_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("negated period disturbed"); // RL18

  c_throttle: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    state_r == ST_ASSERT ##1 state_r == ST_NEGATE);
  c_burst: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    state_r == ST_BURST && expire);
  c_break: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    brk_evt && !cpu_halt_request_n_o);
  c_port: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) sw_req);
endmodule : halt_throttle_ctrl
`default_nettype wire

// >>> rtl/sync_bank.sv
// Two-flop synchroniser, one per bit.
// Assumes inputs come from pins outside the reference clock domain.
`timescale 1ns/1ns
`default_nettype none
module sync_bank #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i, // Reference clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic [WIDTH-1:0] async_i, // Pin levels
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_r;
      logic stab_r;
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
          meta_r <= 1'b0;
          stab_r <= 1'b0;
        end else begin
          meta_r <= async_i[g];
          stab_r <= meta_r;
        end
      end
      assign sync_o[g] = stab_r;
    end
  endgenerate
endmodule : sync_bank
`default_nettype wire

// >>> rtl/tick_pulse.sv
// Free-running divider giving a one-cycle pulse every PERIOD cycles.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tick_pulse #(
  parameter int PERIOD = 800
) (
  input wire logic ref_clk_i, // Reference clock
  input wire logic rst_b_i, // Sync reset, active low
  output logic tick_o // One-cycle pulse
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt_r;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule : tick_pulse
`default_nettype wire

// >>> tb/cpu_core_model.sv
// Processor side of the halt request: measures asserted and negated spans.
// Assumes the request is registered on ref_clk_i.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
  input wire logic ref_clk_i, // Reference clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic cpu_halt_request_n_i, // Halt request, active low
  output var int lo_len_o, // Last full asserted span
  output var int hi_len_o, // Last full negated span
  output var int edges_o // Transitions seen
);
  int run;
  logic last;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      run <= 0;
      last <= 1'b1;
      edges_o <= 0;
      lo_len_o <= 0;
      hi_len_o <= 0;
    end else if (cpu_halt_request_n_i !== last) begin
      if (last === 1'b0) lo_len_o <= run;
      else hi_len_o <= run;
      edges_o <= edges_o + 1;
      run <= 1;
      last <= cpu_halt_request_n_i;
    end else begin
      run <= run + 1;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// >>> tb/halt_throttle_ctrl_tb.sv
// Self-checking bench for the halt-request and throttle controller.
// Assumes the design and cpu_core_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module halt_throttle_ctrl_tb;
  import halt_ctrl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = 12'h000;
  logic [DATA_W-1:0] pwdata_i = 32'h0;
  logic pm_port_read_i = 1'b0;
  logic burst_event_i = 1'b0;
  logic [IRQ_W-1:0] irq_i = 16'h0000;
  logic [DATA_W-1:0] prdata_o;
  logic [DATA_W-1:0] rd;
  logic pready_o, pslverr_o, halt_n, bus_clock_stop_en_o, standby_tick_o, err;
  logic [1:0] halt_request_mode_o;
  int n_errors = 0;
  int n_compared = 0;
  int lo_len, hi_len, n_edges, n, base;
  logic [9:0] idxs [6] = '{BURST_IDX, CLKCTL_IDX, ASSERT_IDX, NEGATE_IDX, BRK_LO_IDX, BRK_HI_IDX};
  logic [7:0] masks [6] = '{8'hFF, 8'h9F, 8'hFF, 8'hFF, 8'hFB, 8'hDF};

  halt_throttle_ctrl uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pm_port_read_i(pm_port_read_i),
    .irq_i(irq_i), .burst_event_i(burst_event_i), .cpu_halt_request_n_o(halt_n),
    .halt_request_mode_o(halt_request_mode_o), .bus_clock_stop_en_o(bus_clock_stop_en_o),
    .standby_tick_o(standby_tick_o));
  cpu_core_model cpu (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cpu_halt_request_n_i(halt_n),
    .lo_len_o(lo_len), .hi_len_o(hi_len), .edges_o(n_edges));

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic results();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    `CHK(pready_o, 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h0, e});
  endtask : rdchk

  task automatic wait_halt(input logic v, input int lim);
    n = 0;
    while (halt_n !== v && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK(halt_n, v);
  endtask : wait_halt

  task automatic pulse_irq(input int line);
    irq_i[line] <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    irq_i[line] <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask : pulse_irq

  task automatic pulse_burst();
    burst_event_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    burst_event_i <= 1'b0;
  endtask : pulse_burst

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    results();
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(idxs[i], 8'h00);
    for (int i = 0; i < 6; i++) if (i != 1) apb(1'b1, idxs[i], 8'hFF);
    for (int i = 0; i < 6; i++) if (i != 1) rdchk(idxs[i], masks[i]);
    apb(1'b1, CLKCTL_IDX, 8'hED);
    rdchk(CLKCTL_IDX, 8'h8D);
    `CHK(halt_request_mode_o, 2'b11);
    `CHK(bus_clock_stop_en_o, 1'b1);
    apb(1'b1, CLKCTL_IDX, 8'h00);
    @(posedge ref_clk_i);
    `CHK(bus_clock_stop_en_o, 1'b0);
    apb(1'b0, 10'h0D5, 8'h00);
    `CHK(err, 1'b1);
    `CHK(rd, 32'h0);
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CLKCTL_IDX, 8'(m << 2));
      @(posedge ref_clk_i);
      pm_port_read_i <= 1'b1;
      @(posedge ref_clk_i);
      pm_port_read_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      `CHK(halt_n, m == 0);
      if (m != 0) begin
        pulse_irq(m[0] ? 2 : 13);
        `CHK(halt_n, 1'b0);
        pulse_irq(m == 1 ? 0 : (m == 2 ? 8 : 15));
        `CHK(halt_n, 1'b1);
      end
    end
    $display("port read test done");
    apb(1'b1, ASSERT_IDX, 8'h02);
    apb(1'b1, NEGATE_IDX, 8'h03);
    apb(1'b1, CLKCTL_IDX, 8'h02);
    wait_halt(1'b0, 5);
    base = n_edges;
    n = 0;
    while (n_edges < base + 5 && n < 20000) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK(n_edges >= base + 5, 1'b1);
    `CHK(lo_len >= 2 * TICK_CYC - 1 && lo_len <= 2 * TICK_CYC + 1, 1'b1);
    `CHK(hi_len >= 3 * TICK_CYC - 1 && hi_len <= 3 * TICK_CYC + 1, 1'b1);
    wait_halt(1'b0, 3000);
    pulse_irq(0);
    `CHK(halt_n, 1'b1);
    wait_halt(1'b0, 3000);
    @(posedge ref_clk_i);
    `CHK(hi_len >= 2 * TICK_CYC - 5 && hi_len <= 3 * TICK_CYC + 5, 1'b1);
    apb(1'b1, CLKCTL_IDX, 8'h00);
    pulse_irq(0);
    repeat (3000) @(posedge ref_clk_i);
    `CHK(halt_n, 1'b1);
    $display("throttle test done");
    apb(1'b1, BURST_IDX, 8'h02);
    apb(1'b1, CLKCTL_IDX, 8'h10);
    pulse_burst();
    repeat (700) @(posedge ref_clk_i);
    `CHK(halt_n, 1'b1);
    apb(1'b0, STATUS_IDX, 8'h00);
    `CHK(rd[2:0], 3'b010);
    pulse_burst();
    repeat (700) @(posedge ref_clk_i);
    `CHK(halt_n, 1'b1);
    wait_halt(1'b0, 1000);
    apb(1'b1, CLKCTL_IDX, 8'h00);
    pulse_irq(0);
    `CHK(halt_n, 1'b1);
    pulse_burst();
    repeat (2000) @(posedge ref_clk_i);
    `CHK(halt_n, 1'b1);
    $display("burst test done");
    `CHK(standby_tick_o, 1'b0);
    results();
  end
endmodule : halt_throttle_ctrl_tb
`default_nettype wire
